// [mlt_panel_model.sv]
// Panel and video buffer model facing the timing controller.
module mlt_panel_model #(
  parameter logic [127:0] PAT = 128'h0
) (
  input  wire logic         aclk,
  input  wire logic [12:0]  fetch_addr,
  input  wire logic         pixel_shift_clock,
  input  wire logic         line_clock,
  input  wire logic         ac_bias,
  input  wire logic         frame_start,
  output      logic [127:0] vid_data,
  output      int           line_px,
  output      int           frame_lines,
  output      int           bias_run,
  output      real          gap_ns,
  output      real          span_ns
);
  timeunit 1ns;
  timeprecision 1ps;
  int   px = 0;
  int   ln = 0;
  int   bl = 0;
  real  t0 = 0.0;
  real  t1 = 0.0;
  logic ac_q = 1'b0;
  ////////////////////////////////////////////////////////////////////
  // Odd words inverted, so a stuck fetch address shows
  assign vid_data = PAT ^ {128{fetch_addr[0]}};
  always @(posedge aclk) begin
    if (pixel_shift_clock === 1'b1) begin
      if (px == 0) begin
        gap_ns = $realtime - t1;
        t0 = $realtime;
      end
      px++;
      t1 = $realtime;
      span_ns = t1 - t0;
    end
    if (line_clock === 1'b1) begin
      line_px = px;
      px = 0;
      ln++;
      bl++;
      if (ac_bias !== ac_q) begin
        bias_run = bl;
        bl = 0;
        ac_q = ac_bias;
      end
      if (frame_start === 1'b1) begin
        frame_lines = ln;
        ln = 0;
      end
    end
  end
endmodule : mlt_panel_model

// [mlt_pkg.sv]
// Constants for the monochrome panel timing controller.
// Function
// R1: Control word holds depth select, gray enable, bias, pixel prescale, line length, buffer size.
// R2: Buffer size field is quad words minus one; fetch wraps after that count.
// R3: Line has (field plus one) times sixteen pixels, then a line clock.
// R4: Pixel rate is the source rate divided by pixel prescale plus one.
// R5: Pixel prescale of zero stops the pixel clock entirely.
// R6: Software picks prescale for roughly seventy hertz refresh, never faster.
// R7: Shift clock low phase doubles after each line clock high pulse.
// R8: Bias output toggles after bias field plus one line clocks.
// R9: Software sets bias field per panel maker, not dividing line count.
// R10: Gray disabled maps one buffer bit to one pixel; enabled gives grayscale.
// R11: With gray enabled, depth select clear gives two bits, set four bits.
// R12: After the whole buffer is fetched, counters restart at buffer start.
package mlt_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OFS_CONTROL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS    = 4'h4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  // Control word field positions
  localparam int DEPTH_BIT  = 31;
  localparam int GRAY_BIT   = 30;
  localparam int BIAS_HI    = 29;
  localparam int BIAS_LO    = 25;
  localparam int PRESC_HI   = 24;
  localparam int PRESC_LO   = 19;
  localparam int LLEN_HI    = 18;
  localparam int LLEN_LO    = 13;
  localparam int BUFSZ_HI   = 12;
  localparam int BUFSZ_LO   = 0;
  localparam int QW_BITS    = 128;
  localparam int PIX_UNIT   = 16;
  localparam int PIX_UNIT_LG = 4;
  localparam int LINE_W     = 11;
  localparam int LINES_W    = 16;
  localparam logic [7:0] BPP_1 = 8'h01;
  localparam logic [7:0] BPP_2 = 8'h02;
  localparam logic [7:0] BPP_4 = 8'h04;
  typedef enum logic [0:0] {PH_PIXEL, PH_LINE} mlt_phase_t;
endpackage : mlt_pkg

// [mlt_timing.sv]
// Panel timing controller with AXI4-Lite control and status registers.
module mlt_timing (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output      logic         s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output      logic         s_axi_wready,
  output      logic [1:0]   s_axi_bresp,
  output      logic         s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output      logic         s_axi_arready,
  output      logic [31:0]  s_axi_rdata,
  output      logic [1:0]   s_axi_rresp,
  output      logic         s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         pix_src_clk,
  input  wire logic [127:0] vid_data,
  output      logic [12:0]  fetch_addr,
  output      logic         pixel_shift_clock,
  output      logic         line_clock,
  output      logic         ac_bias,
  output      logic [3:0]   pix_value,
  output      logic         frame_start
);
  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [3:0]  awa_ff, nxt_awa, wst_ff, nxt_wst;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
  logic [31:0] status_w;

  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready  = !w_ff && !bv_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;

  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_wst = wst_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_wst = s_axi_wstrb;
    end
    if (nxt_aw && nxt_w && !bv_ff) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      if (nxt_awa == mlt_pkg::OFS_CONTROL) begin
        for (int i = 0; i < 4; i++) begin
          if (nxt_wst[i]) begin
            nxt_ctrl[i*8 +: 8] = nxt_wd[i*8 +: 8]; // R1
          end
        end
        nxt_br = mlt_pkg::RESP_OKAY;
      end else if (nxt_awa == mlt_pkg::OFS_STATUS) begin
        nxt_br = mlt_pkg::RESP_OKAY;
      end else begin
        nxt_br = mlt_pkg::RESP_SLVERR;
      end
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rv = 1'b1;
      if (s_axi_araddr == mlt_pkg::OFS_CONTROL) begin
        nxt_rd = ctrl_ff;
        nxt_rr = mlt_pkg::RESP_OKAY;
      end else if (s_axi_araddr == mlt_pkg::OFS_STATUS) begin
        nxt_rd = status_w;
        nxt_rr = mlt_pkg::RESP_OKAY;
      end else begin
        nxt_rd = 32'h0000_0000;
        nxt_rr = mlt_pkg::RESP_SLVERR;
      end
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= mlt_pkg::CONTROL_RESET;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      awa_ff <= 4'h0;
      wst_ff <= 4'h0;
      wd_ff <= 32'h0000_0000;
      rd_ff <= 32'h0000_0000;
      br_ff <= 2'b00;
      rr_ff <= 2'b00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      bv_ff <= nxt_bv;
      rv_ff <= nxt_rv;
      awa_ff <= nxt_awa;
      wst_ff <= nxt_wst;
      wd_ff <= nxt_wd;
      rd_ff <= nxt_rd;
      br_ff <= nxt_br;
      rr_ff <= nxt_rr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  logic       f_depth, f_gray;
  logic [4:0] f_bias;
  logic [5:0] f_presc, f_llen;
  logic [12:0] f_bufsz;
  logic [7:0] bpp;
  localparam int LINE_END_W = mlt_pkg::LINE_W;
  logic [LINE_END_W-1:0] line_last;

  assign f_depth = ctrl_ff[mlt_pkg::DEPTH_BIT];
  assign f_gray  = ctrl_ff[mlt_pkg::GRAY_BIT];
  assign f_bias  = ctrl_ff[mlt_pkg::BIAS_HI:mlt_pkg::BIAS_LO];
  assign f_presc = ctrl_ff[mlt_pkg::PRESC_HI:mlt_pkg::PRESC_LO];
  assign f_llen  = ctrl_ff[mlt_pkg::LLEN_HI:mlt_pkg::LLEN_LO];
  assign f_bufsz = ctrl_ff[mlt_pkg::BUFSZ_HI:mlt_pkg::BUFSZ_LO];
  assign bpp = !f_gray ? mlt_pkg::BPP_1 : (f_depth ? mlt_pkg::BPP_4 : mlt_pkg::BPP_2); // R10 R11
  // Last pixel index of a line
  assign line_last = {1'b0, f_llen, 4'(mlt_pkg::PIX_UNIT - 1)}; // R3

  ////////////////////////////////////////////////////////////////////////////
  // Source clock sampling and pixel divider
  logic       src_s1_ff, src_s2_ff, src_s3_ff;
  logic [5:0] div_ff, nxt_div;
  logic       src_tick, pix_tick;

  assign src_tick = src_s2_ff && !src_s3_ff;
  assign pix_tick = src_tick && (f_presc != 6'h00) && (div_ff >= f_presc); // R4 R5

  always_comb begin
    nxt_div = div_ff;
    if (f_presc == 6'h00) begin
      nxt_div = 6'h00; // R5
    end else if (src_tick) begin
      nxt_div = (div_ff >= f_presc) ? 6'h00 : div_ff + 6'h01; // R4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s1_ff <= 1'b0;
      src_s2_ff <= 1'b0;
      src_s3_ff <= 1'b0;
      div_ff <= 6'h00;
    end else begin
      src_s1_ff <= pix_src_clk;
      src_s2_ff <= src_s1_ff;
      src_s3_ff <= src_s2_ff;
      div_ff <= nxt_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel, line and buffer walk
  mlt_pkg::mlt_phase_t ph_ff, nxt_ph;
  logic [10:0]  pix_ff, nxt_pix;
  logic [6:0]   bit_ff, nxt_bit;
  logic [12:0]  qw_ff, nxt_qw;
  logic [127:0] word_ff, nxt_word;
  logic [4:0]   bias_cnt_ff, nxt_bias_cnt;
  logic [15:0]  lines_ff, nxt_lines;
  logic         psc_ff, nxt_psc, lc_ff, nxt_lc, ac_ff, nxt_ac, fs_ff, nxt_fs;
  logic [3:0]   pv_ff, nxt_pv;

  assign status_w = {3'h0, lines_ff[12:0], 3'h0, qw_ff};

  always_comb begin
    logic [127:0] w;
    logic [7:0]   nb;
    w = (bit_ff == 7'h00) ? vid_data : word_ff;
    nb = {1'b0, bit_ff} + bpp;
    nxt_ph = ph_ff;
    nxt_pix = pix_ff;
    nxt_bit = bit_ff;
    nxt_qw = qw_ff;
    nxt_word = word_ff;
    nxt_bias_cnt = bias_cnt_ff;
    nxt_lines = lines_ff;
    nxt_ac = ac_ff;
    nxt_pv = pv_ff;
    nxt_psc = 1'b0;
    nxt_lc = 1'b0;
    nxt_fs = 1'b0;
    if (pix_tick) begin
      case (ph_ff)
        mlt_pkg::PH_PIXEL: begin
          nxt_psc = 1'b1;
          nxt_word = w;
          nxt_pv = 4'((w >> bit_ff) & 128'((9'h001 << bpp) - 9'h001)); // R10 R11
          nxt_bit = nb[6:0];
          if (pix_ff >= line_last) begin
            nxt_pix = 11'h000;
            nxt_ph = mlt_pkg::PH_LINE; // R3
          end else begin
            nxt_pix = pix_ff + 11'h001;
          end
          if (nb[7]) begin
            // Word used up; wrap after the programmed count
            if (qw_ff >= f_bufsz) begin
              // Cut line: a walk misaligned by a new setting still ends its frame
              nxt_qw = 13'h0000; // R2 R12
              nxt_bit = 7'h00; // R12
              nxt_pix = 11'h000; // R12
              nxt_ph = mlt_pkg::PH_LINE; // R12
            end else begin
              nxt_qw = qw_ff + 13'h0001; // R2
            end
          end
        end
        mlt_pkg::PH_LINE: begin
          // Slot with no shift edge stretches the shift clock low time
          nxt_lc = 1'b1; // R3 R7
          nxt_ph = mlt_pkg::PH_PIXEL; // R7
          nxt_lines = lines_ff + 16'h0001;
          if (bias_cnt_ff >= f_bias) begin
            nxt_bias_cnt = 5'h00;
            nxt_ac = !ac_ff; // R8
          end else begin
            nxt_bias_cnt = bias_cnt_ff + 5'h01; // R8
          end
          if (qw_ff == 13'h0000 && bit_ff == 7'h00) begin
            nxt_lines = 16'h0000; // R12
            nxt_fs = 1'b1;
          end
        end
        default: begin
          nxt_ph = mlt_pkg::PH_PIXEL;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_ff <= mlt_pkg::PH_PIXEL;
      pix_ff <= 11'h000;
      bit_ff <= 7'h00;
      qw_ff <= 13'h0000;
      word_ff <= 128'h0;
      bias_cnt_ff <= 5'h00;
      lines_ff <= 16'h0000;
      psc_ff <= 1'b0;
      lc_ff <= 1'b0;
      ac_ff <= 1'b0;
      fs_ff <= 1'b0;
      pv_ff <= 4'h0;
    end else begin
      ph_ff <= nxt_ph;
      pix_ff <= nxt_pix;
      bit_ff <= nxt_bit;
      qw_ff <= nxt_qw;
      word_ff <= nxt_word;
      bias_cnt_ff <= nxt_bias_cnt;
      lines_ff <= nxt_lines;
      psc_ff <= nxt_psc;
      lc_ff <= nxt_lc;
      ac_ff <= nxt_ac;
      fs_ff <= nxt_fs;
      pv_ff <= nxt_pv;
    end
  end

  assign fetch_addr = qw_ff;
  assign pixel_shift_clock = psc_ff;
  assign line_clock = lc_ff;
  assign ac_bias = ac_ff;
  assign pix_value = pv_ff;
  assign frame_start = fs_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_no_presc_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (f_presc == 6'h00) |=> !pixel_shift_clock && !line_clock)
    else $error("pixel clock with zero prescale");
  a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    pix_tick && $stable(f_presc) |=> !pix_tick[*2])
    else $error("pixel ticks too close");
  a_line_no_shift: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    line_clock |-> !pixel_shift_clock)
    else $error("shift edge during line pulse");
  a_line_after_last: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    pix_tick && ph_ff == mlt_pkg::PH_PIXEL && pix_ff >= line_last |=>
    ph_ff == mlt_pkg::PH_LINE && pix_ff == 11'h000)
    else $error("line end missed");
  a_bias_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    $changed(ac_bias) |-> $past(line_clock) == 1'b0 && line_clock)
    else $error("bias toggled off a line clock");
  a_bias_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    line_clock && bias_cnt_ff != 5'h00 |-> $stable(ac_bias))
    else $error("bias toggled early");
  a_qw_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // R2 R12
    $stable(f_bufsz) && $changed(qw_ff) |->
    qw_ff == 13'h0000 || qw_ff == $past(qw_ff) + 13'h0001)
    else $error("buffer walk skipped");
  a_mono_pixel: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    pixel_shift_clock && $past(!f_gray) |-> pix_value[3:1] == 3'h0)
    else $error("mono pixel wider than one bit");
  a_depth_two: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    pixel_shift_clock && $past(f_gray && !f_depth) |-> pix_value[3:2] == 2'h0)
    else $error("two-bit pixel too wide");
  a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    $rose(s_axi_bvalid) && awa_ff == mlt_pkg::OFS_CONTROL && wst_ff == 4'hf |->
    ctrl_ff == wd_ff)
    else $error("control write lost");
endmodule : mlt_timing

// [mlt_timing_tb_top.sv]
// Self-checking bench for the panel timing controller.
module mlt_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] PAT = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam real TSRC = 27.127;
  typedef struct {int md; int gs; int ac; int ps; int ll; int bpp; int lines;} mlt_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, pclk = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, pix;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, psc, lck, acb, fst;
  logic [1:0] bresp, rresp, rsp;
  logic [12:0] faddr;
  logic [127:0] vdata;
  int line_px, frame_lines, bias_run, n, miscompares = 0, cmp_count = 0, cyc = 0;
  real gap_ns, span_ns;
  mlt_row_t r;
  // Small panels keep frames short; bias period never divides a frame's lines
  mlt_row_t rows[3] = '{'{0,0,2,1,0,1,16}, '{0,1,2,2,1,2,4}, '{1,1,4,1,0,4,4}};
  always #5 aclk = ~aclk;
  always #13.5635 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////
  mlt_timing u_mlt_timing (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pix_src_clk(pclk), .vid_data(vdata), .fetch_addr(faddr),
    .pixel_shift_clock(psc), .line_clock(lck), .ac_bias(acb), .pix_value(pix),
    .frame_start(fst));
  mlt_panel_model #(.PAT(PAT)) u_mlt_panel_model (.aclk(aclk), .fetch_addr(faddr),
    .pixel_shift_clock(psc), .line_clock(lck), .ac_bias(acb), .frame_start(fst),
    .vid_data(vdata), .line_px(line_px), .frame_lines(frame_lines),
    .bias_run(bias_run), .gap_ns(gap_ns), .span_ns(span_ns));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic bit near(input real a, input real e);
    return (a > e - 25.0) && (a < e + 25.0);
  endfunction : near
  function automatic logic [31:0] mk(input mlt_row_t x);
    logic [31:0] c;
    c = 32'h0000_0001;
    c[mlt_pkg::DEPTH_BIT] = x.md[0];
    c[mlt_pkg::GRAY_BIT] = x.gs[0];
    c[mlt_pkg::BIAS_HI:mlt_pkg::BIAS_LO] = x.ac[4:0];
    c[mlt_pkg::PRESC_HI:mlt_pkg::PRESC_LO] = x.ps[5:0];
    c[mlt_pkg::LLEN_HI:mlt_pkg::LLEN_LO] = x.ll[5:0];
    return c;
  endfunction : mk
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_read
  // Waits are bounded; a missing pulse falls through to a failing compare
  task automatic wait_pulse(input bit frame);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((frame ? fst : psc) !== 1'b1 && n < 20000);
  endtask : wait_pulse
  task automatic quiet;
    n = 0;
    repeat (400) begin
      @(posedge aclk);
      if (psc === 1'b1 || lck === 1'b1) n++;
    end
  endtask : quiet
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(mlt_pkg::OFS_CONTROL);
    chk(rd, mlt_pkg::CONTROL_RESET);
    axi_write(mlt_pkg::OFS_CONTROL, 32'hffffffff, 4'hf);
    chk(rsp, mlt_pkg::RESP_OKAY);
    axi_write(mlt_pkg::OFS_CONTROL, 32'h0, 4'h2);
    axi_write(mlt_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk(rsp, mlt_pkg::RESP_OKAY);
    axi_read(mlt_pkg::OFS_CONTROL);
    chk(rd, 32'hffff00ff);
    axi_write(4'h8, 32'h0, 4'hf);
    chk(rsp, mlt_pkg::RESP_SLVERR);
    axi_read(4'h8);
    chk({rd[29:0], rsp}, {30'h0, mlt_pkg::RESP_SLVERR});
    foreach (rows[i]) begin
      r = rows[i];
      axi_write(mlt_pkg::OFS_CONTROL, mk(r), 4'hf);
      repeat (4) wait_pulse(1'b1);
      // Model updates its counts at the same edge; read one edge later
      @(posedge aclk);
      chk(line_px, (r.ll + 1) * 16);
      chk(frame_lines, r.lines);
      chk(bias_run, r.ac + 1);
      chk(near(span_ns, ((r.ll + 1) * 16 - 1) * (r.ps + 1) * TSRC), 1);
      chk(near(gap_ns, 2 * (r.ps + 1) * TSRC), 1);
      for (int k = 0; k < (r.ll + 1) * 16; k++) begin
        wait_pulse(1'b0);
        chk(pix, 32'((PAT >> (k * r.bpp)) & ((1 << r.bpp) - 1)));
      end
    end
    @(posedge aclk) aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(mlt_pkg::OFS_CONTROL);
    chk(rd, mlt_pkg::CONTROL_RESET);
    axi_read(mlt_pkg::OFS_STATUS);
    chk(rd, 32'h0000_0000);
    quiet();
    chk(n, 0);
    axi_write(mlt_pkg::OFS_CONTROL, mk('{1,1,13,0,39,4,0}), 4'hf);
    quiet();
    chk(n, 0);
    tally_and_finish();
  end
endmodule : mlt_timing_tb_top
